// *** lsde_core.sv ***
// decode and one-cycle execute of logical shift instructions
// ---------------------------------------------------------------
// Notes on behaviour
// RULE_01: flagged left shift by immediate writes zero-filled result, flags.
// RULE_02: flagged left shift by register writes result and updates flags.
// RULE_03: register shift counts use only the low eight bits of the register.
// RULE_04: plain right shift by immediate zero-fills and leaves flags alone.
// RULE_05: plain right shift by register zero-fills and leaves flags alone.
// RULE_06: left immediate amount is five bits, split high/low in wide form.
// RULE_07: right immediate amount of zero means a shift of thirty-two.
// RULE_08: narrow left shifts set flags only outside a predicated block.
// RULE_09: narrow right shifts set no flags inside a predicated block.
// RULE_10: narrow register form uses one field as source and destination.
// RULE_11: every form executes as a register copy with a shift type.
// RULE_12: wide forms, and narrow forms inside a predicated block, need the full-feature extension.
// RULE_13: flags take n from bit 31, z on zero, c last out, v unchanged.
// RULE_14: register counts of 32 up give zero; zero leaves value and carry.
// ---------------------------------------------------------------
module lsde_core
  import lsde_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // instruction issue
  input  wire logic        i_valid,
  input  wire logic        i_wide,
  input  wire logic [31:0] i_instr,
  input  wire logic        i_inside_predicated_block,
  input  wire logic        i_full_ext,
  // operand values read for the decoded fields
  input  wire logic [31:0] i_src_value,
  input  wire logic [31:0] i_amt_value,
  input  wire logic        i_carry_in,
  // decoded operand fields
  output logic [3:0]       o_source_reg_field,
  output logic [3:0]       o_shift_amount_reg_field,
  // result
  output logic             o_wr_en,
  output logic [3:0]       o_wr_reg,
  output logic [31:0]      o_wr_data,
  output logic             o_flag_we,
  output logic             o_flag_n,
  output logic             o_flag_z,
  output logic             o_flag_c,
  output logic             o_undef
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  lsde_op_e    op;
  logic [1:0]  stype;
  logic [4:0]  short_shift_amount;
  logic [3:0]  dst;
  logic [3:0]  srcf;
  logic [3:0]  amtf;
  logic        setf;
  logic        need_ext;
  logic        hit;

  // narrow decode is combinational; operands arrive the same cycle
  always_comb begin
    op = LSDE_OP_NONE;
    stype = TYPE_LSL;
    short_shift_amount = AMT_ZERO;
    dst = 4'h0;
    srcf = 4'h0;
    amtf = 4'h0;
    setf = 1'b0;
    need_ext = 1'b1;
    if (!i_wide) begin
      srcf = {1'b0, i_instr[5:3]};
      dst = {1'b0, i_instr[2:0]};
      short_shift_amount = i_instr[10:6];
      if (i_instr[15:11] == NARROW_IMM_LSL &&
          i_instr[10:6] != AMT_ZERO) begin
        op = LSDE_OP_IMM; // RULE_11
        setf = !i_inside_predicated_block; // RULE_08
        need_ext = i_inside_predicated_block; // RULE_12
      end else if (i_instr[15:11] == NARROW_IMM_LSR) begin
        op = LSDE_OP_IMM;
        stype = TYPE_LSR;
        setf = !i_inside_predicated_block; // RULE_09
        need_ext = i_inside_predicated_block; // RULE_12
      end else if (i_instr[15:6] == NARROW_REG_LSL ||
                   i_instr[15:6] == NARROW_REG_LSR) begin
        op = LSDE_OP_REG; // RULE_11
        stype = i_instr[6] ? TYPE_LSR : TYPE_LSL;
        srcf = {1'b0, i_instr[2:0]}; // RULE_10
        amtf = {1'b0, i_instr[5:3]};
        setf = !i_inside_predicated_block; // RULE_08
        need_ext = i_inside_predicated_block; // RULE_12
      end
    end else begin
      dst = i_instr[11:8];
      srcf = i_instr[3:0];
      setf = i_instr[20];
      if ({i_instr[31:21], 1'b0} == WIDE_IMM_TOP &&
          i_instr[19:16] == WIDE_IMM_RN && !i_instr[5]) begin
        op = LSDE_OP_IMM; // RULE_11
        stype = {1'b0, i_instr[4]};
        short_shift_amount = {i_instr[14:12], i_instr[7:6]}; // RULE_06
        if (stype == TYPE_LSL && short_shift_amount == AMT_ZERO)
          op = LSDE_OP_NONE; // plain copy, not ours
      end else if ({i_instr[31:22], 1'b0} == WIDE_REG_TOP &&
                   !i_instr[22] &&
                   i_instr[15:12] == WIDE_REG_PAT &&
                   i_instr[7:4] == WIDE_REG_ZERO) begin
        op = LSDE_OP_REG; // RULE_11
        stype = {1'b0, i_instr[21]};
        amtf = i_instr[3:0];
        srcf = i_instr[19:16];
      end
    end
    hit = (op != LSDE_OP_NONE) && (stype[1] == 1'b0);
  end

  // ---------------------------------------------------------------
  // execute
  // ---------------------------------------------------------------
  logic [7:0]  cnt;
  logic [31:0] res;
  logic        cout;
  logic [32:0] wide_l;
  logic [32:0] wide_r;

  always_comb begin
    if (op == LSDE_OP_REG)
      cnt = i_amt_value[7:0]; // RULE_03
    else if (stype == TYPE_LSR && short_shift_amount == AMT_ZERO)
      cnt = {2'b00, AMT_FULL}; // RULE_07
    else
      cnt = {3'b000, short_shift_amount}; // RULE_06
    wide_l = {1'b0, i_src_value} << cnt[5:0];
    wide_r = {i_src_value, 1'b0} >> cnt[5:0];
    res = i_src_value;
    cout = i_carry_in;
    if (cnt == 8'h00) begin
      res = i_src_value; // RULE_14
      cout = i_carry_in;
    end else if (cnt > RS_LIMIT) begin
      res = '0; // RULE_14
      cout = 1'b0;
    end else if (stype == TYPE_LSL) begin
      res = wide_l[31:0]; // RULE_01 RULE_02
      cout = wide_l[32];
    end else begin
      res = wide_r[32:1]; // RULE_04 RULE_05
      cout = wide_r[0];
    end
  end

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  logic go;
  assign go = i_valid && hit && !(need_ext && !i_full_ext);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wr_en <= 1'b0;
      o_wr_reg <= 4'h0;
      o_wr_data <= '0;
      o_flag_we <= 1'b0;
      o_flag_n <= 1'b0;
      o_flag_z <= 1'b0;
      o_flag_c <= 1'b0;
      o_undef <= 1'b0;
      o_source_reg_field <= 4'h0;
      o_shift_amount_reg_field <= 4'h0;
    end else begin
      o_wr_en <= go;
      o_wr_reg <= dst;
      o_wr_data <= res;
      o_flag_we <= go && setf; // RULE_04 RULE_05
      o_flag_n <= res[WORD_W-1]; // RULE_13
      o_flag_z <= (res == '0); // RULE_13
      o_flag_c <= cout; // RULE_13
      o_undef <= i_valid && hit && need_ext && !i_full_ext; // RULE_12
      o_source_reg_field <= srcf;
      o_shift_amount_reg_field <= amtf;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_zero_flag;
    @(posedge i_mclk) disable iff (!i_resetn)
      o_flag_we |-> (o_flag_z == (o_wr_data == '0));
  endproperty
  a_zero_flag: assert property (p_zero_flag) // RULE_13
    else $error("zero flag mismatch");

  property p_neg_flag;
    @(posedge i_mclk) disable iff (!i_resetn)
      o_flag_we |-> o_flag_n == o_wr_data[31];
  endproperty
  a_neg_flag: assert property (p_neg_flag) // RULE_13
    else $error("negative flag mismatch");

  property p_flag_needs_write;
    @(posedge i_mclk) disable iff (!i_resetn)
      o_flag_we |-> o_wr_en;
  endproperty
  a_flag_needs_write: assert property (p_flag_needs_write) // RULE_11
    else $error("flag update without write");

  property p_no_ext_undef;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_valid && i_wide && hit && !i_full_ext) |=> !o_wr_en && o_undef;
  endproperty
  a_no_ext_undef: assert property (p_no_ext_undef) // RULE_12
    else $error("wide shift executed without extension");

  property p_pred_noflag;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_valid && !i_wide && i_inside_predicated_block) |=> !o_flag_we;
  endproperty
  a_pred_noflag: assert property (p_pred_noflag) // RULE_08
    else $error("flags set inside predicated block");

  property p_big_count;
    @(posedge i_mclk) disable iff (!i_resetn)
      (go && op == LSDE_OP_REG && i_amt_value[7:0] > RS_LIMIT)
        |=> o_wr_data == '0;
  endproperty
  a_big_count: assert property (p_big_count) // RULE_14
    else $error("large count not zero");

  property p_zero_count;
    @(posedge i_mclk) disable iff (!i_resetn)
      (go && op == LSDE_OP_REG && i_amt_value[7:0] == 8'h00)
        |=> o_wr_data == $past(i_src_value) &&
            o_flag_c == $past(i_carry_in);
  endproperty
  a_zero_count: assert property (p_zero_count) // RULE_14
    else $error("zero count changed value");

  property p_lsr32;
    @(posedge i_mclk) disable iff (!i_resetn)
      (go && op == LSDE_OP_IMM && stype == TYPE_LSR &&
       short_shift_amount == AMT_ZERO)
        |=> o_wr_data == '0 && o_flag_c == $past(i_src_value[31]);
  endproperty
  a_lsr32: assert property (p_lsr32) // RULE_07
    else $error("right shift of 32 wrong");

endmodule : lsde_core

// *** lsde_core_tb.sv ***
// self-checking bench for the logical shift decode/execute core
module lsde_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // signals and expected-result notes
  // ---------------------------------------------------------------
  typedef struct packed {
    logic en; logic [3:0] rd; logic [31:0] d;
    logic fw; logic n; logic z; logic c; logic u; logic [3:0] sf;
    logic [3:0] af;
  } lsde_note_s;
  logic        i_mclk = 0, i_resetn = 0, i_valid = 0, i_wide = 0;
  logic        i_inside = 0, i_ext = 0, i_cin = 0;
  logic [31:0] i_instr = 0, i_src = 0, i_amt = 0, rng = 32'h3F, r;
  logic [31:0] rnd_i, rnd_s, rnd_a;
  logic [3:0]  o_sf, o_af, o_wr_reg;
  logic        o_wr_en, o_fwe, o_n, o_z, o_c, o_undef;
  logic [31:0] o_wr_data;
  lsde_note_s  notes[$];
  lsde_note_s  ex;
  int          bad_count, total_checks, cyc;

  always #50 i_mclk = ~i_mclk;

  lsde_core i_lsde_core (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_valid(i_valid), .i_wide(i_wide), .i_instr(i_instr),
    .i_inside_predicated_block(i_inside), .i_full_ext(i_ext),
    .i_src_value(i_src), .i_amt_value(i_amt), .i_carry_in(i_cin),
    .o_source_reg_field(o_sf), .o_shift_amount_reg_field(o_af),
    .o_wr_en(o_wr_en), .o_wr_reg(o_wr_reg), .o_wr_data(o_wr_data),
    .o_flag_we(o_fwe), .o_flag_n(o_n), .o_flag_z(o_z), .o_flag_c(o_c),
    .o_undef(o_undef));

  // ---------------------------------------------------------------
  // reference model and helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic lsde_note_s model(logic w, logic [31:0] i, logic ib,
      logic e, logic [31:0] s, logic [31:0] a, logic ci);
    lsde_note_s o;
    logic [1:0] k;
    logic t, f;
    logic [8:0] n;
    logic [32:0] x;
    o = '0; k = 0; t = 0; f = !ib; n = 0;
    if (!w && i[15:12] == 4'h0) begin
      k = 1; t = i[11]; n = {4'h0, i[10:6]};
      o.rd = {1'b0, i[2:0]}; o.sf = {1'b0, i[5:3]};
    end else if (!w && i[15:7] == 9'h081) begin
      k = 2; t = i[6]; n = {1'b0, a[7:0]};
      o.rd = {1'b0, i[2:0]}; o.sf = o.rd;
      o.af = {1'b0, i[5:3]};
    end else if (w && i[31:21] == 11'h752 && i[19:15] == 5'h1E
        && !i[5]) begin
      k = 1; t = i[4]; n = {4'h0, i[14:12], i[7:6]};
      o.rd = i[11:8]; o.sf = i[3:0]; f = i[20];
    end else if (w && i[31:22] == 10'h3E8 && i[15:12] == 4'hF
        && i[7:4] == 4'h0) begin
      k = 2; t = i[21]; n = {1'b0, a[7:0]};
      o.rd = i[11:8]; o.sf = i[19:16]; f = i[20];
      o.af = i[3:0];
    end
    if (k == 1 && t && n == 0) n = 9'd32;
    if (k == 1 && !t && n == 0) k = 0;
    if (k == 0) return '0;
    if ((w || ib) && !e) begin
      o = '0; o.u = 1;
      return o;
    end
    if (t && n != 0 && n <= 9'd32) begin
      x = {s, 1'b0} >> n; o.d = x[32:1]; o.c = x[0];
    end else begin
      x = (n == 0) ? {ci, s} : (n > 9'd32) ? 33'h0 : {1'b0, s} << n;
      o.d = x[31:0]; o.c = x[32];
    end
    o.en = 1; o.fw = f; o.n = o.d[31]; o.z = (o.d == 0);
    return o;
  endfunction : model

  task automatic go(logic w, logic [31:0] i, logic ib, logic e,
      logic [31:0] s, logic [31:0] a, logic ci);
    @(posedge i_mclk);
    #2;
    i_valid = 1; i_wide = w; i_instr = i; i_inside = ib; i_ext = e;
    i_src = s; i_amt = a; i_cin = ci;
    notes.push_back(model(w, i, ib, e, s, a, ci));
  endtask : go

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // result watcher and hang guard
  // ---------------------------------------------------------------
  always @(posedge i_mclk) begin
    #1;
    if (notes.size() > 0) begin
      ex = notes.pop_front();
      chk("wr_en", {31'h0, ex.en}, {31'h0, o_wr_en});
      chk("undef", {31'h0, ex.u}, {31'h0, o_undef});
      chk("flag_we", {31'h0, ex.fw}, {31'h0, o_fwe});
      if (ex.en) begin
        chk("wr_data", ex.d, o_wr_data);
        chk("wr_reg", {28'h0, ex.rd}, {28'h0, o_wr_reg});
        chk("src_field", {28'h0, ex.sf}, {28'h0, o_sf});
        chk("amt_field", {28'h0, ex.af}, {28'h0, o_af});
      end
      if (ex.fw) chk("flags", {29'h0, ex.n, ex.z, ex.c},
                     {29'h0, o_n, o_z, o_c});
    end
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // stimulus: edge cases first, then random back-to-back traffic
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_mclk);
    #2;
    i_resetn = 1;
    go(0, 32'h0088, 0, 0, 32'h1, 0, 0);
    go(0, 32'h07CA, 0, 0, 32'h3, 0, 0);
    go(0, 32'h0808, 0, 0, 32'h8000_0000, 0, 0);
    go(0, 32'h4088, 0, 0, 32'h1, 32'h120, 0);
    go(0, 32'h4088, 0, 0, 32'h5, 32'hFFFF_FF00, 1);
    go(0, 32'h40C8, 0, 0, 32'hF0, 32'h21, 1);
    go(0, 32'h0088, 1, 0, 32'h1, 0, 0);
    go(0, 32'h0088, 1, 1, 32'h1, 0, 0);
    go(0, 32'h40C8, 1, 1, 32'h80, 32'h4, 0);
    go(0, 32'h1008, 0, 1, 32'h1, 0, 0);
    go(1, 32'hEA5F_1041, 0, 1, 32'h0800_0001, 0, 0);
    go(1, 32'hEA4F_0011, 0, 1, 32'hFFFF_FFFF, 0, 1);
    go(1, 32'hFA21_F002, 0, 1, 32'h8000_0000, 32'h4, 0);
    go(1, 32'hFA21_F002, 0, 0, 32'h8000_0000, 32'h4, 0);
    repeat (400) begin
      // locals only: the live pins still hold the previous instruction
      r = xs();
      rnd_s = xs();
      rnd_a = xs();
      if (!r[21]) rnd_a[7:6] = 2'h0;
      case (r[1:0])
        2'h0: rnd_i = {16'h0, 4'h0, r[4], r[9:5], r[12:10], r[15:13]};
        2'h1: rnd_i = {11'h752, r[20], 5'h1E, r[14:12], r[11:8], r[7:6],
                       1'b0, r[4], r[3:0]};
        2'h2: rnd_i = {16'h0, 9'h081, r[4], r[11:6]};
        default: rnd_i = {10'h3E8, r[4], r[20] & ~r[4], r[19:16], 4'hF,
                          r[11:8], 4'h0, r[3:0]};
      endcase
      go(r[0], rnd_i, r[22], r[23] | r[24], rnd_s, rnd_a, r[25]);
    end
    @(posedge i_mclk);
    #2;
    i_valid = 0;
    repeat (3) @(posedge i_mclk);
    stop_test();
  end
endmodule : lsde_core_tb

// *** lsde_pkg.sv ***
// constants and types for the logical shift decode/execute block
package lsde_pkg;
  // ---------------------------------------------------------------
  // encoding fields
  // ---------------------------------------------------------------
  localparam logic [4:0]  NARROW_IMM_LSL = 5'h00;   // [15:11]
  localparam logic [4:0]  NARROW_IMM_LSR = 5'h01;
  localparam logic [9:0]  NARROW_REG_LSL = 10'h102; // [15:6]
  localparam logic [9:0]  NARROW_REG_LSR = 10'h103;
  localparam logic [11:0] WIDE_IMM_TOP   = 12'hEA4; // [31:20] s masked
  localparam logic [3:0]  WIDE_IMM_RN    = 4'hF;    // [19:16]
  localparam logic [10:0] WIDE_REG_TOP   = 11'h7D0; // [31:21] t masked
  localparam logic [3:0]  WIDE_REG_PAT   = 4'hF;    // [15:12]
  localparam logic [3:0]  WIDE_REG_ZERO  = 4'h0;    // [7:4]
  localparam logic [1:0]  TYPE_LSL       = 2'h0;
  localparam logic [1:0]  TYPE_LSR       = 2'h1;
  localparam logic [4:0]  AMT_ZERO       = 5'h00;
  localparam logic [5:0]  AMT_FULL       = 6'h20;   // 32
  localparam logic [7:0]  RS_LIMIT       = 8'h20;   // 32
  localparam int          WORD_W         = 32;

  typedef enum logic [1:0] {
    LSDE_OP_NONE,
    LSDE_OP_IMM,
    LSDE_OP_REG
  } lsde_op_e;
endpackage : lsde_pkg
